// file: adcm_defines.svh
// Register offsets, field positions, reset values and decimation constants
// for the channel standby and mode profile register bank.
// Assumes it is included by bare name from design files.
`ifndef ADCM_DEFINES_SVH
`define ADCM_DEFINES_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define ADCM_OFS_STANDBY     8'h00
`define ADCM_OFS_PROFILE_A   8'h01
`define ADCM_OFS_PROFILE_B   8'h02
`define ADCM_OFS_PROFILE_SEL 8'h03

// ************************************************************
// Reset values
// ************************************************************
`define ADCM_RST_STANDBY     8'h00
`define ADCM_RST_PROFILE     8'h0d
`define ADCM_RST_PROFILE_SEL 8'h00

// ************************************************************
// Field positions and masks
// ************************************************************
`define ADCM_STANDBY_MASK    8'h0f
`define ADCM_PROFILE_MASK    8'h0f
`define ADCM_SEL_MASK        8'h33
`define ADCM_FILT_BIT        3
`define ADCM_DECIM_MSB       2
`define ADCM_SEL_CH0         0
`define ADCM_SEL_CH1         1
`define ADCM_SEL_CH2         4
`define ADCM_SEL_CH3         5
`define ADCM_HDR_REPEAT_BIT  6

// ************************************************************
// Decimation
// ************************************************************
`define ADCM_DECIM_BASE      11'h020
`define ADCM_DECIM_MAX_CODE  3'h5

`endif

// file: adcm_pkg.sv
// Types shared by the channel mode configuration block.
// Assumes adcm_defines.svh is on the include path.
package adcm_pkg;
    typedef logic [2:0] adcm_decim_code_t;
    typedef logic [9:0] adcm_decim_cnt_t;
    typedef enum logic {
        ADCM_FILT_WIDEBAND = 1'b0,
        ADCM_FILT_SINC5    = 1'b1
    } adcm_filter_t;
endpackage

// file: adcm_prof_if.sv
// Carrier between the register bank and one profile decimation counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface adcm_prof_if;
    import adcm_pkg::*;
    adcm_decim_code_t code;
    logic             restart;
    logic             tick;
    logic             wrap;
    modport ctl (output code, output restart, output tick, input wrap);
    modport ctr (input code, input restart, input tick, output wrap);
endinterface

// file: adcm_decim_ctr.sv
// Output-rate counter for one mode profile: counts modulator ticks and
// pulses wrap once per decimated output sample.
// Assumes tick is a one-cycle enable on clk.
`timescale 1ns/100ps
`include "adcm_defines.svh"
module adcm_decim_ctr (
    input  wire logic clk,
    input  wire logic resetn,
    adcm_prof_if.ctr  prof
);
    import adcm_pkg::*;

    adcm_decim_code_t code_eff;
    adcm_decim_cnt_t  cnt_lim;
    adcm_decim_cnt_t  cnt_r;
    adcm_decim_cnt_t  cnt_nxt;
    logic             last;

    // Codes above the top step all run at the slowest ratio
    assign code_eff = (prof.code > `ADCM_DECIM_MAX_CODE) ? `ADCM_DECIM_MAX_CODE : prof.code;
    assign cnt_lim  = 10'((`ADCM_DECIM_BASE << code_eff) - 11'h001);
    assign last     = (cnt_r == cnt_lim);
    assign cnt_nxt  = prof.restart ? 10'h000 :
                      (prof.tick ? (last ? 10'h000 : cnt_r + 10'h001) : cnt_r);
    assign prof.wrap = prof.tick && last && !prof.restart;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// file: adcm_chan_cfg.sv
// Channel standby and mode profile register bank with its output-frame
// side effects: standby slots, repeated-data marking and data-ready rate.
// Assumes register writes and reads arrive from the serial control port
// decoder on clk, and mod_tick and conv_result come from logic on clk.
//
// Contract
// - One standby bit per channel in bits 3..0; 1 is standby.
// - Standby channel keeps its slot: zero header and zero 24-bit result.
// - Channel 0 standby also disables the common-mode voltage output.
// - Channel 2 standby also disables the crystal excitation circuit.
// - Two profiles: bit 3 filter select, bits 2..0 decimation code.
// - Codes 0..4 give x32..x512; codes 5..7 give x1024.
// - Select bits 0,1,4,5 map channels 0..3 to profile A or B.
// - Data-ready follows the faster of the selected output rates.
// - Slower channels show zero data with repeated-data bit between results.
// - Profiles reset to 0x0d; standby and select reset to 0x00.
`timescale 1ns/100ps
`include "adcm_defines.svh"
module adcm_chan_cfg #(
    parameter int NCH = 4
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  mod_tick,
    input  wire logic [NCH*24-1:0]     conv_result,
    output logic                       data_ready,
    output logic [NCH*8-1:0]           frame_hdr,
    output logic [NCH*24-1:0]          frame_data,
    output logic [NCH-1:0]             chan_enable,
    output logic [NCH-1:0]             chan_filter_sinc5,
    output logic                       common_mode_out_en,
    output logic                       xtal_exc_en
);
    import adcm_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] channel_standby_r;
    logic [7:0] profile_a_config_r;
    logic [7:0] profile_b_config_r;
    logic [7:0] profile_select_r;
    logic [7:0] reg_rdata_r;
    logic [7:0] rd_mux;

    logic wr_standby;
    logic wr_prof_a;
    logic wr_prof_b;
    logic wr_sel;

    assign wr_standby = reg_wr && (reg_addr == `ADCM_OFS_STANDBY);
    assign wr_prof_a  = reg_wr && (reg_addr == `ADCM_OFS_PROFILE_A);
    assign wr_prof_b  = reg_wr && (reg_addr == `ADCM_OFS_PROFILE_B);
    assign wr_sel     = reg_wr && (reg_addr == `ADCM_OFS_PROFILE_SEL);

    // Undefined bits are never stored, so they read back as zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_standby_r  <= `ADCM_RST_STANDBY;
            profile_a_config_r <= `ADCM_RST_PROFILE;
            profile_b_config_r <= `ADCM_RST_PROFILE;
            profile_select_r   <= `ADCM_RST_PROFILE_SEL;
        end else begin
            if (wr_standby) begin
                channel_standby_r <= reg_wdata & `ADCM_STANDBY_MASK;
            end
            if (wr_prof_a) begin
                profile_a_config_r <= reg_wdata & `ADCM_PROFILE_MASK;
            end
            if (wr_prof_b) begin
                profile_b_config_r <= reg_wdata & `ADCM_PROFILE_MASK;
            end
            if (wr_sel) begin
                profile_select_r <= reg_wdata & `ADCM_SEL_MASK;
            end
        end
    end

    assign rd_mux = (reg_addr == `ADCM_OFS_STANDBY)     ? channel_standby_r  :
                    (reg_addr == `ADCM_OFS_PROFILE_A)   ? profile_a_config_r :
                    (reg_addr == `ADCM_OFS_PROFILE_B)   ? profile_b_config_r :
                    (reg_addr == `ADCM_OFS_PROFILE_SEL) ? profile_select_r   : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = reg_rdata_r;

    // ************************************************************
    // Profile rate counters
    // ************************************************************
    // Any profile write restarts both counters so the two output rates
    // stay phase aligned and slow samples land on fast frame boundaries.
    adcm_prof_if prof_a ();
    adcm_prof_if prof_b ();
    logic restart;
    assign restart = wr_prof_a || wr_prof_b || wr_sel;

    assign prof_a.code    = profile_a_config_r[`ADCM_DECIM_MSB:0];
    assign prof_a.restart = restart;
    assign prof_a.tick    = mod_tick;
    assign prof_b.code    = profile_b_config_r[`ADCM_DECIM_MSB:0];
    assign prof_b.restart = restart;
    assign prof_b.tick    = mod_tick;

    adcm_decim_ctr u_ctr_a (
        .clk    (clk),
        .resetn (resetn),
        .prof   (prof_a)
    );
    adcm_decim_ctr u_ctr_b (
        .clk    (clk),
        .resetn (resetn),
        .prof   (prof_b)
    );

    // ************************************************************
    // Frame rate selection
    // ************************************************************
    logic [NCH-1:0] sel_b;
    logic           a_used;
    logic           b_used;
    logic [2:0]     eff_a;
    logic [2:0]     eff_b;
    logic           fast_is_a;
    logic           frame_tick;

    assign sel_b = {profile_select_r[`ADCM_SEL_CH3], profile_select_r[`ADCM_SEL_CH2],
                    profile_select_r[`ADCM_SEL_CH1], profile_select_r[`ADCM_SEL_CH0]};
    assign a_used = ~&sel_b;
    assign b_used = |sel_b;
    assign eff_a  = (prof_a.code > `ADCM_DECIM_MAX_CODE) ? `ADCM_DECIM_MAX_CODE : prof_a.code;
    assign eff_b  = (prof_b.code > `ADCM_DECIM_MAX_CODE) ? `ADCM_DECIM_MAX_CODE : prof_b.code;
    // Smaller code means fewer ticks per result, so a faster rate
    assign fast_is_a  = a_used && (!b_used || (eff_a <= eff_b));
    assign frame_tick = fast_is_a ? prof_a.wrap : prof_b.wrap;

    // ************************************************************
    // Per-channel frame slots
    // ************************************************************
    logic [NCH*8-1:0]  hdr_nxt;
    logic [NCH*24-1:0] data_nxt;
    logic [NCH*8-1:0]  frame_hdr_r;
    logic [NCH*24-1:0] frame_data_r;
    logic [NCH-1:0]    filt_nxt;
    logic              data_ready_r;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic       stby;
            logic       fresh;
            logic [7:0] prof;
            assign stby  = channel_standby_r[g];
            assign prof  = sel_b[g] ? profile_b_config_r : profile_a_config_r;
            assign fresh = sel_b[g] ? prof_b.wrap : prof_a.wrap;
            assign filt_nxt[g] = prof[`ADCM_FILT_BIT];
            // Header: repeat flag, channel number, filter, decimation code
            assign hdr_nxt[g*8 +: 8] = stby ? 8'h00 :
                {1'b0, !fresh, 2'(g), prof[3:0]};
            assign data_nxt[g*24 +: 24] = (stby || !fresh) ? 24'h000000 :
                                          conv_result[g*24 +: 24];
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_hdr_r  <= '0;
            frame_data_r <= '0;
            data_ready_r <= 1'b0;
        end else begin
            data_ready_r <= frame_tick;
            if (frame_tick) begin
                frame_hdr_r  <= hdr_nxt;
                frame_data_r <= data_nxt;
            end
        end
    end
    assign data_ready = data_ready_r;
    assign frame_hdr  = frame_hdr_r;
    assign frame_data = frame_data_r;

    // ************************************************************
    // Analog enables
    // ************************************************************
    logic [NCH-1:0] chan_enable_r;
    logic [NCH-1:0] chan_filter_r;
    logic           cm_en_r;
    logic           xtal_en_r;

    // Host must keep channels 0 and 2 up while it relies on these outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chan_enable_r <= '1;
            chan_filter_r <= '1;
            cm_en_r       <= 1'b1;
            xtal_en_r     <= 1'b1;
        end else begin
            chan_enable_r <= ~channel_standby_r[NCH-1:0];
            chan_filter_r <= filt_nxt;
            cm_en_r       <= !channel_standby_r[0];
            xtal_en_r     <= !channel_standby_r[2];
        end
    end
    assign chan_enable        = chan_enable_r;
    assign chan_filter_sinc5  = chan_filter_r;
    assign common_mode_out_en = cm_en_r;
    assign xtal_exc_en        = xtal_en_r;
endmodule

// file: adcm_chan_cfg_assertions.sv
// Concurrent checks on the ports of the channel mode register bank.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
module adcm_chan_cfg_chk #(
    parameter int NCH = 4
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              data_ready,
    input wire logic [NCH*8-1:0]  frame_hdr,
    input wire logic [NCH*24-1:0] frame_data,
    input wire logic [NCH-1:0]    chan_enable,
    input wire logic              common_mode_out_en,
    input wire logic              xtal_exc_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ****************************************************
    // Properties
    // ****************************************************
    property p_cm; reg_wr && reg_addr == 8'h00
        |-> ##2 common_mode_out_en == !$past(reg_wdata[0], 2); endproperty
    a_cm: assert property (p_cm) else $error("common mode enable off channel 0");
    property p_xt; reg_wr && reg_addr == 8'h00
        |-> ##2 xtal_exc_en == !$past(reg_wdata[2], 2); endproperty
    a_xt: assert property (p_xt) else $error("crystal enable off channel 2");
    property p_sby; reg_wr && reg_addr == 8'h00 |-> ##2 chan_enable == ~$past(reg_wdata[3:0], 2);
    endproperty
    a_sby: assert property (p_sby) else $error("standby write not applied");
    property p_unm; reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_msk; reg_rd && reg_addr == 8'h03 |=> (reg_rdata & 8'hcc) == 8'h00; endproperty
    a_msk: assert property (p_msk) else $error("select undefined bits set");
    property p_drp; data_ready |=> !data_ready; endproperty
    a_drp: assert property (p_drp) else $error("data ready longer than a pulse");
    property p_sb; data_ready && !chan_enable[0] && !$past(chan_enable[0])
        |-> frame_hdr[7:0] == 8'h00 && frame_data[23:0] == 24'h0; endproperty
    a_sb: assert property (p_sb) else $error("standby slot not zero");
    property p_rep; data_ready && frame_hdr[6] |-> frame_data[23:0] == 24'h0; endproperty
    a_rep: assert property (p_rep) else $error("repeated slot data not zero");
    property p_rst; $rose(resetn) |-> chan_enable == 4'hf; endproperty
    a_rst: assert property (p_rst) else $error("channels not enabled after reset");
endmodule
bind adcm_chan_cfg adcm_chan_cfg_chk #(.NCH(NCH)) i_adcm_chan_cfg_chk (.clk(clk), .resetn(resetn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .data_ready(data_ready), .frame_hdr(frame_hdr),
    .frame_data(frame_data), .chan_enable(chan_enable),
    .common_mode_out_en(common_mode_out_en), .xtal_exc_en(xtal_exc_en));

// file: adcm_host_model.sv
// Modulator tick source on the far side of the frame stream.
// Assumes the bench raises run only while frames are expected.
`timescale 1ns/100ps
module adcm_host_model (
    input  wire logic clk,
    input  wire logic run,
    output logic      mod_tick
);
    // Tick every cycle: the densest spacing stresses the rate counters most.
    // Only driver of the tick; it settles at the first falling edge, inside reset.
    always @(negedge clk) mod_tick <= run;
endmodule

// file: tb_adcm_chan_cfg.sv
// Self-checking bench for the channel mode register bank.
// Assumes the bound checker and the tick source model compile alongside.
`timescale 1ns/100ps
module tb_adcm_chan_cfg;
    import adcm_pkg::*;
    typedef struct {logic [31:0] h; logic [95:0] d; int g;} adcm_exp_t;
    logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [95:0] conv_result = 96'h0, frame_data;
    logic [31:0] frame_hdr;
    logic [3:0]  chan_enable, chan_filter_sinc5;
    logic        mod_tick, data_ready, common_mode_out_en, xtal_exc_en, rd_d = 1'b0;
    logic [7:0]  rq[$];
    adcm_exp_t   fq[$];
    int          fail_count = 0, n_checks = 0, cyc = 0, last = 0;
    always #50 clk = ~clk;
    adcm_chan_cfg #(.NCH(4)) i_adcm_chan_cfg (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mod_tick(mod_tick), .conv_result(conv_result), .data_ready(data_ready),
        .frame_hdr(frame_hdr), .frame_data(frame_data), .chan_enable(chan_enable),
        .chan_filter_sinc5(chan_filter_sinc5), .common_mode_out_en(common_mode_out_en),
        .xtal_exc_en(xtal_exc_en));
    adcm_host_model i_adcm_host_model (.clk(clk), .run(run), .mod_tick(mod_tick));
    // ****************************************************
    // Checking and bus tasks
    // ****************************************************
    task automatic chk(string nm, logic [95:0] e, logic [95:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        rq.push_back(e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
    function automatic int rt(logic [7:0] c);
        return 32 << ((c[2:0] > 3'd5) ? 5 : c[2:0]);
    endfunction
    // Profile writes restart both counters, so frame k lands at k times the fast ratio
    task automatic go(int n, logic [7:0] pa, logic [7:0] pb, logic [7:0] sel, logic [3:0] sb);
        adcm_exp_t  e;
        logic [7:0] c;
        logic [3:0] fl;
        logic       rep;
        int         f, t;
        wr(8'h00, {4'h0, sb});
        wr(8'h01, pa);
        wr(8'h02, pb);
        wr(8'h03, sel);
        @(negedge clk);
        f = 2048;
        for (int g = 0; g < 4; g++) begin
            c = sel[g < 2 ? g : g + 2] ? pb : pa;
            fl[g] = c[3];
            if (rt(c) < f) f = rt(c);
        end
        chk("chan_filter_sinc5", fl, chan_filter_sinc5);
        for (int k = 1; k <= n; k++) begin
            e.g = (k == 1) ? 0 : f;
            for (int g = 0; g < 4; g++) begin
                c = sel[g < 2 ? g : g + 2] ? pb : pa;
                rep = ((k * f) % rt(c)) != 0;
                e.h[g*8+:8] = sb[g] ? 8'h00 : {1'b0, rep, 2'(g), c[3:0]};
                e.d[g*24+:24] = (sb[g] || rep) ? 24'h0 : conv_result[g*24+:24];
            end
            fq.push_back(e);
        end
        run = 1'b1;
        t = 0;
        while (fq.size() != 0 && t < 5000) begin
            @(negedge clk);
            t++;
        end
        run = 1'b0;
        chk("frames_left", 0, fq.size());
        $display("test frames a=%h b=%h sel=%h done", pa, pb, sel);
    endtask
    // ****************************************************
    // Result watcher and main sequence
    // ****************************************************
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        adcm_exp_t e;
        cyc++;
        if (rd_d) chk("reg_rdata", rq.pop_front(), reg_rdata);
        if (data_ready === 1'b1 && fq.size() != 0) begin
            e = fq.pop_front();
            chk("frame_hdr", e.h, frame_hdr);
            chk("frame_data", e.d, frame_data);
            if (e.g != 0) chk("frame_gap", 96'(e.g), 96'(cyc - last));
        end
        if (data_ready === 1'b1) last = cyc;
    end
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
    initial begin
        void'($urandom(32'hb0fd22dd));
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        chk("chan_enable", 4'hf, chan_enable);
        for (int a = 0; a < 5; a++) rd(8'(a), (a == 1 || a == 2) ? 8'h0d : 8'h00);
        $display("test reset values done");
        for (int a = 0; a < 5; a++) wr(8'(a), 8'hff);
        for (int a = 0; a < 5; a++) rd(8'(a), a == 3 ? 8'h33 : a == 4 ? 8'h00 : 8'h0f);
        chk("side_enables", 6'h00, {chan_enable, common_mode_out_en, xtal_exc_en});
        wr(8'h00, 8'h05);
        @(negedge clk);
        chk("side_enables", 6'h28, {chan_enable, common_mode_out_en, xtal_exc_en});
        $display("test masks and standby done");
        conv_result = {$urandom, $urandom, $urandom};
        go(4, 8'h00, 8'h01, 8'h30, 4'h1);
        go(4, 8'h0a, 8'h08, 8'h30, 4'h0);
        for (int c = 0; c < 8; c++) begin
            conv_result = {$urandom, $urandom, $urandom};
            go(2, {4'h0, 1'($urandom), 3'(c)}, 8'h0d, 8'h00, 4'h0);
        end
        // Reset in mid-run with every channel in standby and profile A changed
        wr(8'h00, 8'h0f);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk("reset_outputs", 10'h3ff, {chan_enable, chan_filter_sinc5,
            common_mode_out_en, xtal_exc_en});
        for (int a = 0; a < 4; a++) rd(8'(a), (a == 1 || a == 2) ? 8'h0d : 8'h00);
        @(negedge clk);
        $display("test reset in mid-run done");
        final_report();
    end
endmodule
